// ==== hw/pcmd_pkg.sv ====
// Constants shared by the per-function command register bank.
// Assumes one 10 MHz clock and configuration cycles already decoded.
package pcmd_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int PCMD_NUM_FUNC = 3;
    localparam int PCMD_FUNC_W = 2;
    localparam int PCMD_ADDR_W = 8;
    localparam int PCMD_DATA_W = 32;
    localparam int PCMD_REG_W = 16;
    localparam int PCMD_BE_W = 4;
    localparam int PCMD_LANE_W = 8;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] PCMD_CMD_OFFSET = 8'h04;
    localparam logic [15:0] PCMD_CMD_RESET = 16'h0000;
    // Bits 10, 8, 6, 5, 2, 1, 0 are writable, all others read zero
    localparam logic [15:0] PCMD_CMD_WR_MASK = 16'h0567;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int PCMD_B_IO_EN = 0;
    localparam int PCMD_B_MEM_EN = 1;
    localparam int PCMD_B_INIT_EN = 2;
    localparam int PCMD_B_SPECIAL = 3;
    localparam int PCMD_B_WINV_EN = 4;
    localparam int PCMD_B_SNOOP_EN = 5;
    localparam int PCMD_B_PAR_EN = 6;
    localparam int PCMD_B_RSVD7 = 7;
    localparam int PCMD_B_SYSTEM_ERROR_DRIVE_ENABLE = 8;
    localparam int PCMD_B_FAST_BACK_TO_BACK_ENABLE = 9;
    localparam int PCMD_B_INT_MASK = 10;
    localparam int PCMD_B_RESERVED_BITS_LO = 11;
    localparam int PCMD_B_RESERVED_BITS_HI = 15;

    // ************************************************************
    // Read answer sequencer
    // ************************************************************
    typedef enum logic [0:0]
    {
        PCMD_RD_IDLE = 1'b0,
        PCMD_RD_ANSWER = 1'b1
    } pcmd_rd_state_e;

endpackage

// ==== hw/pcmd_cmd_reg.sv ====
// One function's command register with per-byte write enables.
// Assumes the write strobe is already decoded for this function.
`timescale 1ns/1ps

module pcmd_cmd_reg
    import pcmd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Write port
    input wire logic i_wr,
    input wire logic [1:0] i_be,
    input wire logic [PCMD_REG_W-1:0] i_wdata,
    // Stored value
    output logic [PCMD_REG_W-1:0] o_cmd
);

    logic [PCMD_REG_W-1:0] cmd_q;
    logic [PCMD_REG_W-1:0] cmd_d;
    logic [PCMD_REG_W-1:0] lane_mask;

    // ************************************************************
    // Byte lanes
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < PCMD_REG_W / PCMD_LANE_W; g++)
        begin : g_lane
            assign lane_mask[g*PCMD_LANE_W +: PCMD_LANE_W] =
                {PCMD_LANE_W{i_be[g]}};
        end
    endgenerate

    assign cmd_d = (cmd_q & ~(lane_mask & PCMD_CMD_WR_MASK))
                 | (i_wdata & lane_mask & PCMD_CMD_WR_MASK);

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cmd_q <= PCMD_CMD_RESET;
        else if (i_wr)
            cmd_q <= cmd_d;
    end

    assign o_cmd = cmd_q;

endmodule

// ==== hw/pcmd_err_gate.sv ====
// Shared parity and system error reporting for all functions.
// Assumes error detect strobes are one-cycle pulses on i_clk.
`timescale 1ns/1ps

module pcmd_err_gate
    import pcmd_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Combined enables
    input wire logic i_system_error_drive_enable_any,
    input wire logic i_par_en_any,
    // Detected errors
    input wire logic i_addr_par_err,
    input wire logic i_data_par_err,
    // Error reports
    output logic o_serr_assert,
    output logic o_perr_assert
);

    logic serr_q;
    logic perr_q;
    logic serr_d;
    logic perr_d;

    assign serr_d = i_addr_par_err & i_system_error_drive_enable_any & i_par_en_any;
    assign perr_d = i_data_par_err & i_par_en_any;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            serr_q <= 1'b0;
            perr_q <= 1'b0;
        end
        else
        begin
            serr_q <= serr_d;
            perr_q <= perr_d;
        end
    end

    assign o_serr_assert = serr_q;
    assign o_perr_assert = perr_q;

endmodule

// ==== hw/pcmd_top.sv ====
// Command register bank for three functions and the gating it drives.
// Assumes configuration cycles arrive decoded on i_clk, and that the
// target and initiator engines feed hit and request strobes on i_clk.
`timescale 1ns/1ps

module pcmd_top
    import pcmd_pkg::*;
#(
    parameter int NUM_FUNC = PCMD_NUM_FUNC
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Configuration access
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [PCMD_FUNC_W-1:0] i_cfg_func,
    input wire logic [PCMD_ADDR_W-1:0] i_cfg_addr,
    input wire logic [PCMD_BE_W-1:0] i_cfg_be,
    input wire logic [PCMD_DATA_W-1:0] i_cfg_wdata,
    output logic [PCMD_DATA_W-1:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    // Target decode hits, one bit per function
    input wire logic [NUM_FUNC-1:0] i_mem_hit,
    input wire logic [NUM_FUNC-1:0] i_io_hit,
    input wire logic [NUM_FUNC-1:0] i_pal_wr_hit,
    // Initiator and interrupt requests
    input wire logic [NUM_FUNC-1:0] i_init_req,
    input wire logic [NUM_FUNC-1:0] i_int_req,
    // Detected parity errors
    input wire logic i_addr_par_err,
    input wire logic i_data_par_err,
    // Gated claims and requests
    output logic [NUM_FUNC-1:0] o_mem_claim,
    output logic [NUM_FUNC-1:0] o_io_claim,
    output logic [NUM_FUNC-1:0] o_pal_claim,
    output logic [NUM_FUNC-1:0] o_pal_capture,
    output logic [NUM_FUNC-1:0] o_init_req,
    output logic [NUM_FUNC-1:0] o_int_assert,
    // Error reports
    output logic o_serr_assert,
    output logic o_perr_assert
);

    // ************************************************************
    // Parameter check
    // ************************************************************
    // Function select is two bits wide, so at most four functions
    generate
        if (NUM_FUNC < 1 || NUM_FUNC > (1 << PCMD_FUNC_W))
        begin : g_bad_param
            $error("NUM_FUNC out of range for the function select");
        end
        // Each register instance serves exactly two byte lanes
        if (PCMD_REG_W != 2 * PCMD_LANE_W)
        begin : g_bad_lanes
            $error("command register is not two byte lanes wide");
        end
        // The read word must hold the whole register
        if (PCMD_DATA_W < PCMD_REG_W)
        begin : g_bad_word
            $error("read word narrower than the command register");
        end
    endgenerate

    // ************************************************************
    // Declarations
    // ************************************************************
    // Per-function fields
    logic [PCMD_REG_W-1:0] cmd [NUM_FUNC];
    logic [NUM_FUNC-1:0] func_sel;
    logic [NUM_FUNC-1:0] func_wr;
    logic [NUM_FUNC-1:0] system_error_drive_enable_vec;
    logic [NUM_FUNC-1:0] par_en_vec;
    logic [NUM_FUNC-1:0] io_en_vec;
    logic [NUM_FUNC-1:0] mem_en_vec;
    logic [NUM_FUNC-1:0] init_en_vec;
    logic [NUM_FUNC-1:0] snoop_en_vec;
    logic [NUM_FUNC-1:0] int_mask_vec;
    logic [NUM_FUNC-1:0] snoop_hit_vec;

    // Gated next values and their flops
    logic [NUM_FUNC-1:0] mem_claim_d;
    logic [NUM_FUNC-1:0] io_claim_d;
    logic [NUM_FUNC-1:0] pal_claim_d;
    logic [NUM_FUNC-1:0] pal_capture_d;
    logic [NUM_FUNC-1:0] init_req_d;
    logic [NUM_FUNC-1:0] int_assert_d;
    logic [NUM_FUNC-1:0] mem_claim_q;
    logic [NUM_FUNC-1:0] io_claim_q;
    logic [NUM_FUNC-1:0] pal_claim_q;
    logic [NUM_FUNC-1:0] pal_capture_q;
    logic [NUM_FUNC-1:0] init_req_q;
    logic [NUM_FUNC-1:0] int_assert_q;

    // Access decode and read path
    logic addr_is_cmd;
    logic func_valid;
    logic wr_take;
    logic rd_take;
    logic rd_hit;
    logic [PCMD_REG_W-1:0] rd_chain [NUM_FUNC+1];
    logic [PCMD_REG_W-1:0] rd_cmd;
    logic [PCMD_DATA_W-1:0] rd_word;
    logic [PCMD_DATA_W-1:0] rdata_d;
    logic [PCMD_DATA_W-1:0] rdata_q;
    logic rvalid_q;
    pcmd_rd_state_e rd_state_q;
    pcmd_rd_state_e rd_state_d;

    // Shared error enables
    logic system_error_drive_enable_any;
    logic par_en_any;

    // ************************************************************
    // Access decode
    // ************************************************************
    assign addr_is_cmd = (i_cfg_addr == PCMD_CMD_OFFSET);
    assign func_valid = (32'(i_cfg_func) < NUM_FUNC);
    assign wr_take = i_cfg_wr & addr_is_cmd & func_valid;
    // A read is refused while the previous answer is still showing
    assign rd_take = i_cfg_rd & (rd_state_q == PCMD_RD_IDLE);

    // ************************************************************
    // Per-function registers
    // ************************************************************
    genvar f;
    generate
        for (f = 0; f < NUM_FUNC; f++)
        begin : g_func
            assign func_sel[f] = (32'(i_cfg_func) == f);
            assign func_wr[f] = wr_take & func_sel[f];

            pcmd_cmd_reg u_cmd_reg
            (
                .i_clk(i_clk),
                .i_rst_b(i_rst_b),
                .i_wr(func_wr[f]),
                .i_be(i_cfg_be[1:0]),
                .i_wdata(i_cfg_wdata[PCMD_REG_W-1:0]),
                .o_cmd(cmd[f])
            );

            assign io_en_vec[f] = cmd[f][PCMD_B_IO_EN];
            assign mem_en_vec[f] = cmd[f][PCMD_B_MEM_EN];
            assign init_en_vec[f] = cmd[f][PCMD_B_INIT_EN];
            assign snoop_en_vec[f] = cmd[f][PCMD_B_SNOOP_EN];
            assign par_en_vec[f] = cmd[f][PCMD_B_PAR_EN];
            assign system_error_drive_enable_vec[f] = cmd[f][PCMD_B_SYSTEM_ERROR_DRIVE_ENABLE];
            assign int_mask_vec[f] = cmd[f][PCMD_B_INT_MASK];

            assign snoop_hit_vec[f] = i_pal_wr_hit[f] & snoop_en_vec[f];
            // I/O claim gate
            // Palette writes are I/O, so a snooped one is never claimed
            assign io_claim_d[f] = i_io_hit[f] & io_en_vec[f]
                                 & ~snoop_hit_vec[f];
            assign mem_claim_d[f] = i_mem_hit[f] & mem_en_vec[f];
            assign pal_capture_d[f] = snoop_hit_vec[f];
            assign pal_claim_d[f] = i_pal_wr_hit[f] & ~snoop_en_vec[f]
                                  & io_en_vec[f];
            assign init_req_d[f] = i_init_req[f] & init_en_vec[f];
            assign int_assert_d[f] = i_int_req[f] & ~int_mask_vec[f];
        end
    endgenerate

    // ************************************************************
    // Shared error enables
    // ************************************************************
    // Wired OR of enables
    assign system_error_drive_enable_any = |system_error_drive_enable_vec;
    assign par_en_any = |par_en_vec;

    pcmd_err_gate u_err_gate
    (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_system_error_drive_enable_any(system_error_drive_enable_any),
        .i_par_en_any(par_en_any),
        .i_addr_par_err(i_addr_par_err),
        .i_data_par_err(i_data_par_err),
        .o_serr_assert(o_serr_assert),
        .o_perr_assert(o_perr_assert)
    );

    // ************************************************************
    // Read path
    // ************************************************************
    // Select the addressed function
    // An AND-OR chain keeps the select free of priority logic
    assign rd_chain[0] = PCMD_CMD_RESET;
    generate
        for (f = 0; f < NUM_FUNC; f++)
        begin : g_rd_sel
            assign rd_chain[f+1] = rd_chain[f]
                                 | (cmd[f] & {PCMD_REG_W{func_sel[f]}});
        end
    endgenerate
    assign rd_cmd = rd_chain[NUM_FUNC];

    // Other offsets and absent functions answer zero
    assign rd_hit = addr_is_cmd & func_valid;
    // Reserved bits zero
    // Status half is not held here and reads zero
    assign rd_word = {{(PCMD_DATA_W-PCMD_REG_W){1'b0}},
                      rd_cmd & PCMD_CMD_WR_MASK};
    assign rdata_d = rd_hit ? rd_word : {PCMD_DATA_W{1'b0}};

    always_comb
    begin
        rd_state_d = rd_state_q;
        unique case (rd_state_q)
            PCMD_RD_IDLE:
            begin
                if (rd_take)
                    rd_state_d = PCMD_RD_ANSWER;
            end
            PCMD_RD_ANSWER:
            begin
                rd_state_d = PCMD_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rd_state_q <= PCMD_RD_IDLE;
        else
            rd_state_q <= rd_state_d;
    end

    // One-cycle answer strobe
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rvalid_q <= 1'b0;
        else
            rvalid_q <= rd_take;
    end

    // Data stands until the next taken read
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rdata_q <= {PCMD_DATA_W{1'b0}};
        else if (rd_take)
            rdata_q <= rdata_d;
    end

    // ************************************************************
    // Gated outputs
    // ************************************************************
    // Registered so that every output comes from a flip-flop; this
    // costs one cycle of latency between a hit and its claim
    // Memory claim flop
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            mem_claim_q <= '0;
        else
            mem_claim_q <= mem_claim_d;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            io_claim_q <= '0;
        else
            io_claim_q <= io_claim_d;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            pal_claim_q <= '0;
        else
            pal_claim_q <= pal_claim_d;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            pal_capture_q <= '0;
        else
            pal_capture_q <= pal_capture_d;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            init_req_q <= '0;
        else
            init_req_q <= init_req_d;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            int_assert_q <= '0;
        else
            int_assert_q <= int_assert_d;
    end

    // ************************************************************
    // Output wiring
    // ************************************************************
    // Read answer
    assign o_cfg_rdata = rdata_q;
    assign o_cfg_rvalid = rvalid_q;
    // Claims and requests
    assign o_mem_claim = mem_claim_q;
    assign o_io_claim = io_claim_q;
    assign o_pal_claim = pal_claim_q;
    assign o_pal_capture = pal_capture_q;
    assign o_init_req = init_req_q;
    assign o_int_assert = int_assert_q;

endmodule

// ==== sim/pcmd_top_props.sv ====
// Concurrent checks on the command register bank ports.
// Assumes it is bound into pcmd_top and sees only its ports.
`timescale 1ns/1ps

module pcmd_top_chk
    import pcmd_pkg::*;
#(
    parameter int NUM_FUNC = PCMD_NUM_FUNC
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Configuration access
    input wire logic i_cfg_rd,
    input wire logic [PCMD_DATA_W-1:0] o_cfg_rdata,
    input wire logic o_cfg_rvalid,
    // Gating
    input wire logic [NUM_FUNC-1:0] i_mem_hit,
    input wire logic [NUM_FUNC-1:0] i_int_req,
    input wire logic [NUM_FUNC-1:0] i_init_req,
    input wire logic [NUM_FUNC-1:0] o_mem_claim,
    input wire logic [NUM_FUNC-1:0] o_int_assert,
    input wire logic [NUM_FUNC-1:0] o_init_req,
    // Errors
    input wire logic i_addr_par_err,
    input wire logic i_data_par_err,
    input wire logic o_serr_assert,
    input wire logic o_perr_assert
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    rd_answer_a: assert property (
        i_cfg_rd && !o_cfg_rvalid |=> o_cfg_rvalid)
        else $error("read not answered next cycle");
    rd_single_a: assert property (
        o_cfg_rvalid |=> !o_cfg_rvalid)
        else $error("read answer longer than one cycle");
    reserved_bits_high_a: assert property (
        o_cfg_rvalid |-> o_cfg_rdata[15:11] == 5'h00)
        else $error("bits 15 to 11 not zero");
    bit_seven_a: assert property (
        o_cfg_rvalid |-> !o_cfg_rdata[7])
        else $error("bit 7 not zero");
    fbb_zero_a: assert property (
        o_cfg_rvalid |-> !o_cfg_rdata[9])
        else $error("bit 9 not zero");
    winv_zero_a: assert property (
        o_cfg_rvalid |-> !o_cfg_rdata[4])
        else $error("bit 4 not zero");
    special_zero_a: assert property (
        o_cfg_rvalid |-> !o_cfg_rdata[3])
        else $error("bit 3 not zero");
    mem_cause_a: assert property (
        (o_mem_claim & ~$past(i_mem_hit)) == '0)
        else $error("memory claim without hit");
    int_cause_a: assert property (
        (o_int_assert & ~$past(i_int_req)) == '0)
        else $error("interrupt without request");
    init_cause_a: assert property (
        (o_init_req & ~$past(i_init_req)) == '0)
        else $error("initiator request without cause");
    serr_cause_a: assert property (
        o_serr_assert |-> $past(i_addr_par_err))
        else $error("system error without address parity error");
    perr_cause_a: assert property (
        o_perr_assert |-> $past(i_data_par_err))
        else $error("parity error without data parity error");

    cover property (o_cfg_rvalid);
    cover property (o_serr_assert);
    cover property (o_perr_assert);
    cover property (|o_int_assert);
endmodule

bind pcmd_top pcmd_top_chk #(.NUM_FUNC(NUM_FUNC)) u_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cfg_rd(i_cfg_rd),
    .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
    .i_mem_hit(i_mem_hit), .i_int_req(i_int_req), .i_init_req(i_init_req),
    .o_mem_claim(o_mem_claim), .o_int_assert(o_int_assert),
    .o_init_req(o_init_req), .i_addr_par_err(i_addr_par_err),
    .i_data_par_err(i_data_par_err), .o_serr_assert(o_serr_assert),
    .o_perr_assert(o_perr_assert)
);

// ==== sim/pcmd_host_model.sv ====
// Configuration host: issues decoded config reads and writes.
// Assumes one shared clock; requests change 1 ns after a rising edge.
`timescale 1ns/1ps

module pcmd_host_model
    import pcmd_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Configuration access
    output logic o_cfg_wr,
    output logic o_cfg_rd,
    output logic [PCMD_FUNC_W-1:0] o_cfg_func,
    output logic [PCMD_ADDR_W-1:0] o_cfg_addr,
    output logic [PCMD_BE_W-1:0] o_cfg_be,
    output logic [PCMD_DATA_W-1:0] o_cfg_wdata,
    input wire logic [PCMD_DATA_W-1:0] i_cfg_rdata,
    input wire logic i_cfg_rvalid
);
    // Idle address, and after a write the data, are inverted so nothing relies on stale values
    initial
    begin
        o_cfg_wr = 1'b0;
        o_cfg_rd = 1'b0;
        o_cfg_func = 2'h0;
        o_cfg_addr = 8'h00;
        o_cfg_be = 4'h0;
        o_cfg_wdata = 32'h0000_0000;
    end

    task automatic wr(input logic [1:0] f, input logic [7:0] a,
        input logic [3:0] be, input logic [15:0] d);
        @(posedge i_clk);
        #1;
        o_cfg_wr = 1'b1;
        o_cfg_func = f;
        o_cfg_addr = a;
        o_cfg_be = be;
        o_cfg_wdata = {16'hdead, d};
        @(posedge i_clk);
        #1;
        o_cfg_wr = 1'b0;
        o_cfg_addr = ~o_cfg_addr;
        o_cfg_wdata = ~o_cfg_wdata;
    endtask

    task automatic rd(input logic [1:0] f, input logic [7:0] a,
        output logic [31:0] d, output logic v);
        @(posedge i_clk);
        #1;
        o_cfg_rd = 1'b1;
        o_cfg_func = f;
        o_cfg_addr = a;
        @(posedge i_clk);
        #1;
        o_cfg_rd = 1'b0;
        o_cfg_addr = ~o_cfg_addr;
        d = i_cfg_rdata;
        v = i_cfg_rvalid;
    endtask
endmodule

// ==== sim/pcmd_top_tb_top.sv ====
// Self-checking bench for the command register bank.
// Assumes the host model drives config cycles; hits are held here.
`timescale 1ns/1ps

module pcmd_top_tb_top
    import pcmd_pkg::*;
;
    logic clk, rst_b, wr, rd, rvalid, a_err, d_err, serr, perr;
    logic [1:0] func;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata;
    logic [2:0] mem_h, io_h, pal_h, init_r, int_r;
    logic [2:0] mem_c, io_c, pal_c, pal_s, init_o, int_o;
    int miscompares = 0;
    int n_tests = 0;
    localparam logic [7:0] OFF = PCMD_CMD_OFFSET;

    pcmd_host_model host (.i_clk(clk), .o_cfg_wr(wr), .o_cfg_rd(rd),
        .o_cfg_func(func), .o_cfg_addr(addr), .o_cfg_be(be),
        .o_cfg_wdata(wdata), .i_cfg_rdata(rdata), .i_cfg_rvalid(rvalid));

    pcmd_top DUT (.i_clk(clk), .i_rst_b(rst_b), .i_cfg_wr(wr),
        .i_cfg_rd(rd), .i_cfg_func(func), .i_cfg_addr(addr), .i_cfg_be(be),
        .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
        .i_mem_hit(mem_h), .i_io_hit(io_h), .i_pal_wr_hit(pal_h),
        .i_init_req(init_r), .i_int_req(int_r), .i_addr_par_err(a_err),
        .i_data_par_err(d_err), .o_mem_claim(mem_c), .o_io_claim(io_c),
        .o_pal_claim(pal_c), .o_pal_capture(pal_s), .o_init_req(init_o),
        .o_int_assert(int_o), .o_serr_assert(serr), .o_perr_assert(perr));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h, expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic rd_chk(input logic [1:0] f, input logic [7:0] a,
        input logic [15:0] exp);
        logic [31:0] d;
        logic v;
        host.rd(f, a, d, v);
        check(32'(v), 32'h1);
        check(d, {16'h0000, exp});
    endtask

    // Expected packed as mem, io, palette claim, capture, initiator, int
    task automatic gate(input logic [2:0] pal, input logic [17:0] exp);
        @(posedge clk);
        #1;
        pal_h = pal;
        @(posedge clk);
        #1;
        check(32'({mem_c, io_c, pal_c, pal_s, init_o, int_o}), 32'(exp));
    endtask

    task automatic err(input logic a, input logic d, input logic [1:0] exp);
        @(posedge clk);
        #1;
        a_err = a;
        d_err = d;
        @(posedge clk);
        #1;
        a_err = 1'b0;
        d_err = 1'b0;
        check(32'({serr, perr}), 32'(exp));
    endtask

    // Expected run is under a hundred cycles
    initial
    begin
        #(3000 * 100);
        miscompares++;
        conclude;
    end

    initial
    begin
        {mem_h, io_h, pal_h, init_r, int_r} = 15'h0000;
        {a_err, d_err} = 2'b00;
        rst_b = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        {mem_h, io_h, init_r, int_r} = 12'hfff;
        for (int f = 0; f < 3; f++)
            rd_chk(2'(f), OFF, 16'h0000);
        gate(3'h0, {3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7});
        err(1'b1, 1'b1, 2'b00);
        $display("Test reset values done");
        host.wr(2'h0, OFF, 4'h3, 16'hffff);
        rd_chk(2'h0, OFF, 16'h0567);
        rd_chk(2'h1, OFF, 16'h0000);
        host.wr(2'h1, OFF, 4'h1, 16'hffff);
        rd_chk(2'h1, OFF, 16'h0067);
        host.wr(2'h1, OFF, 4'h2, 16'hffff);
        rd_chk(2'h1, OFF, 16'h0567);
        host.wr(2'h2, OFF, 4'hc, 16'hffff);
        host.wr(2'h2, 8'h08, 4'h3, 16'hffff);
        host.wr(2'h3, OFF, 4'h3, 16'hffff);
        rd_chk(2'h2, OFF, 16'h0000);
        rd_chk(2'h0, 8'h08, 16'h0000);
        rd_chk(2'h3, OFF, 16'h0000);
        $display("Test register access done");
        host.wr(2'h2, OFF, 4'h1, 16'h0001);
        gate(3'h0, {3'h3, 3'h7, 3'h0, 3'h0, 3'h3, 3'h4});
        gate(3'h7, {3'h3, 3'h4, 3'h4, 3'h3, 3'h3, 3'h4});
        pal_h = 3'h0;
        $display("Test gating done");
        err(1'b1, 1'b0, 2'b10);
        err(1'b0, 1'b1, 2'b01);
        host.wr(2'h0, OFF, 4'h3, 16'h0000);
        host.wr(2'h1, OFF, 4'h3, 16'h0000);
        host.wr(2'h2, OFF, 4'h1, 16'h0040);
        err(1'b1, 1'b0, 2'b00);
        err(1'b0, 1'b1, 2'b01);
        host.wr(2'h2, OFF, 4'h2, 16'h0100);
        err(1'b1, 1'b0, 2'b10);
        rd_chk(2'h0, OFF, 16'h0000);
        rd_chk(2'h2, OFF, 16'h0140);
        // System error enable alone must not report address parity
        host.wr(2'h2, OFF, 4'h1, 16'h0000);
        err(1'b1, 1'b1, 2'b00);
        rd_chk(2'h2, OFF, 16'h0100);
        $display("Test error reporting done");
        conclude;
    end
endmodule
